// file: rtl/cell_prot_pkg.sv
package cell_prot_pkg;

   // ----------------------------------------
   // Clock and delays
   // ----------------------------------------
   localparam int unsigned CLOCK_HZ           = 40_000_000;
   localparam int unsigned OV_DET_MS          = 1000;
   localparam int unsigned OV_REL_MS          = 16;
   localparam int unsigned UV_DET_MS          = 20;
   localparam int unsigned UV_REL_US          = 1100;
   localparam int unsigned OC_DET_MS          = 12;
   localparam int unsigned OC_REL_MS          = 4;
   localparam int unsigned SC_DET_US          = 400;
   localparam int unsigned OCH_DET_MS         = 16;
   localparam int unsigned OCH_REL_MS         = 4;

   // Cycle counts (exact at 40 MHz)
   localparam int unsigned OV_DET_CYC  = OV_DET_MS * (CLOCK_HZ / 1000);
   localparam int unsigned OV_REL_CYC  = OV_REL_MS * (CLOCK_HZ / 1000);
   localparam int unsigned UV_DET_CYC  = UV_DET_MS * (CLOCK_HZ / 1000);
   localparam int unsigned UV_REL_CYC  = UV_REL_US * (CLOCK_HZ / 1000000);
   localparam int unsigned OC_DET_CYC  = OC_DET_MS * (CLOCK_HZ / 1000);
   localparam int unsigned OC_REL_CYC  = OC_REL_MS * (CLOCK_HZ / 1000);
   localparam int unsigned SC_DET_CYC  = SC_DET_US * (CLOCK_HZ / 1000000);
   localparam int unsigned OCH_DET_CYC = OCH_DET_MS * (CLOCK_HZ / 1000);
   localparam int unsigned OCH_REL_CYC = OCH_REL_MS * (CLOCK_HZ / 1000);

   localparam int unsigned CNT_W = 26;

   // ----------------------------------------
   // Modes
   // ----------------------------------------
   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_OVERCHARGE,
      MODE_OV_SHORT,
      MODE_OVERDISCHARGE,
      MODE_STANDBY,
      MODE_DISCH_OC,
      MODE_SHORT,
      MODE_CHARGE_OC
   } mode_t;

endpackage

// file: rtl/cell_protection_mode_fsm.sv
`timescale 1ns/1ps
// Contract
// - Cell and current within limits: both switches on, normal mode.
// - Over-charge held for its delay: charge switch off, over-charge mode.
// - Leave over-charge after charger gone and cell below release for delay.
// - In over-charge only the short-circuit level is checked for discharge.
// - Short in over-charge: discharge switch off, then pull-down on.
// - Load removed, sense below short level: back to over-charge.
// - Cell below over-discharge for delay: discharge switch off.
// - After over-discharge: pull-up on, bias off, standby.
// - Charger or auto wake level restores bias and leaves standby.
// - Low cell with charger detected: discharge switch on.
// - Cell above release for release delay while charging: normal mode.
// - Charge over-current detection off until cell above release level.
// - Discharge over-current for its delay: discharge off, mode 1, pull-down.
// - Leave mode 1 after load removed and release level held for delay.
// - Short-circuit level for its delay: discharge off, short mode, pull-down.
// - Leave short mode after load removed and release held for delay.
// - Charge over-current for its delay: charge switch off, charge OC mode.
// - Leave charge OC after charger gone and release held for delay.
// - Depleted cell with charger: charge switch on, discharge off.
// - Voltage delays 1 s, 16 ms, 20 ms and 1.1 ms.
// - Current delays 12 ms, 4 ms, 400 us, 16 ms and 4 ms.
module cell_protection_mode_fsm
   import cell_prot_pkg::*;
#(
   parameter int unsigned OV_DET_CYCLES  = OV_DET_CYC,
   parameter int unsigned OV_REL_CYCLES  = OV_REL_CYC,
   parameter int unsigned UV_DET_CYCLES  = UV_DET_CYC,
   parameter int unsigned OC_DET_CYCLES  = OC_DET_CYC,
   parameter int unsigned OC_REL_CYCLES  = OC_REL_CYC,
   parameter int unsigned OCH_DET_CYCLES = OCH_DET_CYC,
   parameter int unsigned OCH_REL_CYCLES = OCH_REL_CYC
)
(
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   // Cell voltage comparators
   input  wire logic i_cell_ge_ov,
   input  wire logic i_cell_lt_ov_rel,
   input  wire logic i_cell_lt_uv,
   input  wire logic i_cell_gt_uv_rel,
   input  wire logic i_cell_gt_auto_wake_release_level,
   // Sense pin comparators
   input  wire logic i_sense_ge_oc,
   input  wire logic i_sense_ge_short_circuit_level,
   input  wire logic i_sense_le_oc_rel,
   input  wire logic i_sense_le_och,
   input  wire logic i_sense_ge_och_rel,
   input  wire logic i_sense_lt_chg_detect,
   // Terminal conditions
   input  wire logic i_charger_present,
   input  wire logic i_load_removed,
   // Outputs
   output logic      o_charge_path_switch,
   output logic      o_discharge_path_switch,
   output logic      o_sense_pull_up,
   output logic      o_sense_pull_down,
   output logic      o_bias_off,
   output mode_t     o_mode
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   localparam int NIN = 13;

   logic [NIN-1:0] raw_in;

   assign raw_in = {i_cell_ge_ov, i_cell_lt_ov_rel, i_cell_lt_uv, i_cell_gt_uv_rel,
                    i_cell_gt_auto_wake_release_level, i_sense_ge_oc,
                    i_sense_ge_short_circuit_level, i_sense_le_oc_rel, i_sense_le_och,
                    i_sense_ge_och_rel, i_sense_lt_chg_detect, i_charger_present,
                    i_load_removed};

   logic ge_ov;
   logic lt_ov_rel;
   logic lt_uv;
   logic gt_uv_rel;
   logic gt_wake;
   logic ge_oc;
   logic ge_sc;
   logic le_oc_rel;
   logic le_och;
   logic ge_och_rel;
   logic lt_chg_det;
   logic charger;
   logic load_gone;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [NIN-1:0] sync1;
      logic [NIN-1:0] sync2;
      mode_t          mode;
      logic           charge_path_switch;
      logic           dis_sw;
      logic           pull_up;
      logic           pull_down;
      logic           bias_off;
   } fsm_state_t;

   fsm_state_t state_q;
   fsm_state_t state_d;

   // Only the second synchroniser stage is read
   assign {ge_ov, lt_ov_rel, lt_uv, gt_uv_rel, gt_wake, ge_oc, ge_sc, le_oc_rel,
           le_och, ge_och_rel, lt_chg_det, charger, load_gone} = state_q.sync2;

   function automatic logic [CNT_W-1:0] to_cnt(input int unsigned v);
      return v[CNT_W-1:0];
   endfunction

   // ----------------------------------------
   // Qualification timers
   // ----------------------------------------
   logic ov_det_c;
   logic ov_rel_c;
   logic uv_det_c;
   logic uv_rel_c;
   logic oc_det_c;
   logic sc_det_c;
   logic dis_rel_c;
   logic och_det_c;
   logic och_rel_c;
   logic ov_det;
   logic ov_rel;
   logic uv_det;
   logic uv_rel;
   logic oc_det;
   logic sc_det;
   logic dis_rel;
   logic och_det;
   logic och_rel;
   logic in_normal;

   assign in_normal = (state_q.mode == MODE_NORMAL);
   assign ov_det_c  = in_normal && ge_ov;
   assign ov_rel_c  = (state_q.mode == MODE_OVERCHARGE) && !charger && lt_ov_rel;
   assign uv_det_c  = in_normal && lt_uv;
   assign uv_rel_c  = (state_q.mode == MODE_OVERDISCHARGE) && gt_uv_rel;
   assign oc_det_c  = in_normal && ge_oc && !ge_sc;
   assign sc_det_c  = (in_normal || state_q.mode == MODE_OVERCHARGE) && ge_sc;
   assign dis_rel_c = (state_q.mode == MODE_DISCH_OC || state_q.mode == MODE_SHORT)
                      && load_gone && le_oc_rel;
   assign och_det_c = in_normal && le_och;
   assign och_rel_c = (state_q.mode == MODE_CHARGE_OC) && !charger && ge_och_rel;

   qual_timer u_ov_det (
      .i_clock  (i_clock),
      .i_sys_rst(i_sys_rst),
      .i_cond   (ov_det_c),
      .i_limit  (to_cnt(OV_DET_CYCLES)),
      .o_done   (ov_det)
   );
   qual_timer u_ov_rel (
      .i_clock  (i_clock),
      .i_sys_rst(i_sys_rst),
      .i_cond   (ov_rel_c),
      .i_limit  (to_cnt(OV_REL_CYCLES)),
      .o_done   (ov_rel)
   );
   qual_timer u_uv_det (
      .i_clock  (i_clock),
      .i_sys_rst(i_sys_rst),
      .i_cond   (uv_det_c),
      .i_limit  (to_cnt(UV_DET_CYCLES)),
      .o_done   (uv_det)
   );
   qual_timer u_uv_rel (
      .i_clock  (i_clock),
      .i_sys_rst(i_sys_rst),
      .i_cond   (uv_rel_c),
      .i_limit  (to_cnt(UV_REL_CYC)),
      .o_done   (uv_rel)
   );
   qual_timer u_oc_det (
      .i_clock  (i_clock),
      .i_sys_rst(i_sys_rst),
      .i_cond   (oc_det_c),
      .i_limit  (to_cnt(OC_DET_CYCLES)),
      .o_done   (oc_det)
   );
   qual_timer u_sc_det (
      .i_clock  (i_clock),
      .i_sys_rst(i_sys_rst),
      .i_cond   (sc_det_c),
      .i_limit  (to_cnt(SC_DET_CYC)),
      .o_done   (sc_det)
   );
   qual_timer u_dis_rel (
      .i_clock  (i_clock),
      .i_sys_rst(i_sys_rst),
      .i_cond   (dis_rel_c),
      .i_limit  (to_cnt(OC_REL_CYCLES)),
      .o_done   (dis_rel)
   );
   qual_timer u_och_det (
      .i_clock  (i_clock),
      .i_sys_rst(i_sys_rst),
      .i_cond   (och_det_c),
      .i_limit  (to_cnt(OCH_DET_CYCLES)),
      .o_done   (och_det)
   );
   qual_timer u_och_rel (
      .i_clock  (i_clock),
      .i_sys_rst(i_sys_rst),
      .i_cond   (och_rel_c),
      .i_limit  (to_cnt(OCH_REL_CYCLES)),
      .o_done   (och_rel)
   );

   // ----------------------------------------
   // Mode control
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      state_d.sync1 = raw_in;
      state_d.sync2 = state_q.sync1;
      case (state_q.mode)
         MODE_NORMAL: begin
            state_d.charge_path_switch    = 1'b1;
            state_d.dis_sw    = 1'b1;
            state_d.pull_up   = 1'b0;
            state_d.pull_down = 1'b0;
            state_d.bias_off  = 1'b0;
            if (sc_det) begin
               state_d.mode      = MODE_SHORT;
               state_d.dis_sw    = 1'b0;
               state_d.pull_down = 1'b1;
            end else if (oc_det) begin
               state_d.mode      = MODE_DISCH_OC;
               state_d.dis_sw    = 1'b0;
               state_d.pull_down = 1'b1;
            end else if (och_det) begin
               state_d.mode   = MODE_CHARGE_OC;
               state_d.charge_path_switch = 1'b0;
            end else if (uv_det) begin
               state_d.mode   = MODE_OVERDISCHARGE;
               state_d.dis_sw = 1'b0;
            end else if (ov_det) begin
               state_d.mode   = MODE_OVERCHARGE;
               state_d.charge_path_switch = 1'b0;
            end
         end
         MODE_OVERCHARGE: begin
            if (sc_det) begin
               state_d.mode   = MODE_OV_SHORT;
               state_d.dis_sw = 1'b0;
            end else if (ov_rel) begin
               state_d.mode   = MODE_NORMAL;
               state_d.charge_path_switch = 1'b1;
            end
         end
         MODE_OV_SHORT: begin
            state_d.pull_down = 1'b1;
            if (state_q.pull_down && load_gone && !ge_sc) begin
               state_d.mode      = MODE_OVERCHARGE;
               state_d.dis_sw    = 1'b1;
               state_d.pull_down = 1'b0;
            end
         end
         MODE_OVERDISCHARGE: begin
            if (!charger) begin
               state_d.mode     = MODE_STANDBY;
               state_d.pull_up  = 1'b1;
               state_d.bias_off = 1'b1;
               state_d.dis_sw   = 1'b0;
            end else begin
               state_d.charge_path_switch = 1'b1;
               state_d.dis_sw = lt_chg_det;
               if (uv_rel) begin
                  state_d.mode   = MODE_NORMAL;
                  state_d.dis_sw = 1'b1;
               end
            end
         end
         MODE_STANDBY: begin
            if (charger || gt_wake) begin
               state_d.mode     = gt_wake && !charger ? MODE_NORMAL : MODE_OVERDISCHARGE;
               state_d.bias_off = 1'b0;
               state_d.pull_up  = 1'b0;
               state_d.dis_sw   = gt_wake && !charger;
            end
         end
         MODE_DISCH_OC, MODE_SHORT: begin
            if (dis_rel) begin
               state_d.mode      = MODE_NORMAL;
               state_d.dis_sw    = 1'b1;
               state_d.pull_down = 1'b0;
            end
         end
         MODE_CHARGE_OC: begin
            if (och_rel) begin
               state_d.mode   = MODE_NORMAL;
               state_d.charge_path_switch = 1'b1;
            end
         end
         default: begin
            state_d.mode = MODE_NORMAL;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         state_q.sync1     <= '0;
         state_q.sync2     <= '0;
         state_q.mode      <= MODE_NORMAL;
         state_q.charge_path_switch    <= 1'b0;
         state_q.dis_sw    <= 1'b0;
         state_q.pull_up   <= 1'b0;
         state_q.pull_down <= 1'b0;
         state_q.bias_off  <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   assign o_charge_path_switch    = state_q.charge_path_switch;
   assign o_discharge_path_switch = state_q.dis_sw;
   assign o_sense_pull_up         = state_q.pull_up;
   assign o_sense_pull_down       = state_q.pull_down;
   assign o_bias_off              = state_q.bias_off;
   assign o_mode                  = state_q.mode;

endmodule // cell_protection_mode_fsm

// file: rtl/qual_timer.sv
`timescale 1ns/1ps
// Counts while the condition holds; restarts when it drops.
module qual_timer
   import cell_prot_pkg::*;
(
   // Clock and reset
   input  wire logic             i_clock,
   input  wire logic             i_sys_rst,
   // Condition
   input  wire logic             i_cond,
   input  wire logic [CNT_W-1:0] i_limit,
   // Result
   output logic                  o_done
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             done;
   } timer_state_t;

   timer_state_t state_q;
   timer_state_t state_d;

   always_comb begin
      state_d = state_q;
      if (!i_cond) begin
         state_d.cnt  = '0;
         state_d.done = 1'b0;
      end else if (state_q.cnt < i_limit - 1'b1) begin
         state_d.cnt  = state_q.cnt + 1'b1;
      end else begin
         state_d.done = 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign o_done = state_q.done;

endmodule // qual_timer

// file: test/cell_protection_mode_fsm_chk.sv
`timescale 1ns/1ps
module cell_protection_mode_fsm_chk
   import cell_prot_pkg::*;
#(
   parameter int unsigned OV_DET_CYCLES  = OV_DET_CYC,
   parameter int unsigned OC_DET_CYCLES  = OC_DET_CYC,
   parameter int unsigned OC_REL_CYCLES  = OC_REL_CYC,
   parameter int unsigned OCH_DET_CYCLES = OCH_DET_CYC
)
(
   // Clock and reset
   input  wire logic  i_clock,
   input  wire logic  i_sys_rst,
   // Watched comparators
   input  wire logic  i_cell_ge_ov,
   input  wire logic  i_sense_ge_oc,
   input  wire logic  i_sense_le_oc_rel,
   input  wire logic  i_sense_le_och,
   // Device outputs
   input  wire logic  o_charge_path_switch,
   input  wire logic  o_discharge_path_switch,
   input  wire logic  o_sense_pull_up,
   input  wire logic  o_sense_pull_down,
   input  wire logic  o_bias_off,
   input  wire mode_t o_mode
);
   // ----------------------------------------
   // Held-condition counters
   // ----------------------------------------
   logic [3:0]  sync1_q;
   logic [3:0]  sync2_q;
   int unsigned ov_cnt_q;
   int unsigned oc_cnt_q;
   int unsigned rel_cnt_q;
   int unsigned och_cnt_q;
   always_ff @(posedge i_clock) begin
      sync1_q <= {i_cell_ge_ov, i_sense_ge_oc, i_sense_le_oc_rel, i_sense_le_och};
      sync2_q <= sync1_q;
      if (i_sys_rst) begin
         ov_cnt_q  <= 0;
         oc_cnt_q  <= 0;
         rel_cnt_q <= 0;
         och_cnt_q <= 0;
      end else begin
         ov_cnt_q  <= sync2_q[3] ? ov_cnt_q + 1 : 0;
         oc_cnt_q  <= sync2_q[2] ? oc_cnt_q + 1 : 0;
         rel_cnt_q <= sync2_q[1] ? rel_cnt_q + 1 : 0;
         och_cnt_q <= sync2_q[0] ? och_cnt_q + 1 : 0;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   normal_switches_a: assert property (
      (o_mode == MODE_NORMAL)[*2] |-> o_charge_path_switch && o_discharge_path_switch)
      else $error("normal mode without both switches on");
   ov_entry_a: assert property (
      $rose(o_mode == MODE_OVERCHARGE) && $past(o_mode) == MODE_NORMAL
      |-> ov_cnt_q >= OV_DET_CYCLES && !o_charge_path_switch) else $error("early over-charge entry");
   ov_no_oc_a: assert property (
      o_mode == MODE_OVERCHARGE |=> o_mode != MODE_DISCH_OC) else $error("over-current in over-charge");
   ov_short_seq_a: assert property (
      $rose(o_mode == MODE_OV_SHORT) |-> !o_discharge_path_switch ##1
      (o_sense_pull_down || o_mode != MODE_OV_SHORT)) else $error("short in over-charge mishandled");
   ov_short_exit_a: assert property (
      o_mode == MODE_OV_SHORT |=> o_mode inside {MODE_OV_SHORT, MODE_OVERCHARGE})
      else $error("short in over-charge left to wrong mode");
   standby_bias_a: assert property (
      (o_mode == MODE_STANDBY)[*2] |-> o_sense_pull_up && o_bias_off) else $error("standby outputs wrong");
   od_no_choc_a: assert property (
      o_mode == MODE_OVERDISCHARGE |=> o_mode != MODE_CHARGE_OC) else $error("charge over-current in od");
   doc_entry_a: assert property (
      $rose(o_mode == MODE_DISCH_OC) |-> oc_cnt_q >= OC_DET_CYCLES && !o_discharge_path_switch)
      else $error("early discharge over-current entry");
   doc_exit_a: assert property (
      $fell(o_mode == MODE_DISCH_OC) |-> rel_cnt_q >= OC_REL_CYCLES && o_mode == MODE_NORMAL)
      else $error("early discharge over-current release");
   short_out_a: assert property (
      (o_mode == MODE_SHORT)[*2] |-> !o_discharge_path_switch && o_sense_pull_down)
      else $error("short mode outputs wrong");
   choc_entry_a: assert property (
      $rose(o_mode == MODE_CHARGE_OC) |-> och_cnt_q >= OCH_DET_CYCLES && !o_charge_path_switch)
      else $error("early charge over-current entry");
endmodule // cell_protection_mode_fsm_chk

bind cell_protection_mode_fsm cell_protection_mode_fsm_chk #(.OV_DET_CYCLES(OV_DET_CYCLES),
   .OC_DET_CYCLES(OC_DET_CYCLES), .OC_REL_CYCLES(OC_REL_CYCLES), .OCH_DET_CYCLES(OCH_DET_CYCLES))
   cell_protection_mode_fsm_chk_inst (.i_clock, .i_sys_rst, .i_cell_ge_ov, .i_sense_ge_oc,
   .i_sense_le_oc_rel, .i_sense_le_och, .o_charge_path_switch, .o_discharge_path_switch,
   .o_sense_pull_up, .o_sense_pull_down, .o_bias_off, .o_mode);

// file: test/pack_model.sv
`timescale 1ns/1ps
// Pack terminals: cell 0 below over-discharge, 1 above release, 2 above wake, 3 over-charge;
// sense 0 idle, 1 over-current, 2 short, 3 charge over-current, 4 pulled low by charger
module pack_model (
   // Commanded levels
   input  wire logic [1:0] i_cell_lvl,
   input  wire logic [2:0] i_sense_lvl,
   input  wire logic       i_charger,
   input  wire logic       i_load_removed,
   input  wire logic       i_pull_down,
   // Comparator results
   output logic            o_ge_ov,
   output logic            o_lt_ov_rel,
   output logic            o_lt_uv,
   output logic            o_gt_uv_rel,
   output logic            o_gt_wake,
   output logic            o_ge_oc,
   output logic            o_ge_sc,
   output logic            o_le_oc_rel,
   output logic            o_le_och,
   output logic            o_ge_och_rel,
   output logic            o_lt_chg_det
);
   logic [2:0] sense;
   // Pull-down drags an unloaded sense pin to idle
   assign sense        = (i_pull_down && i_load_removed) ? 3'h0 : i_sense_lvl;
   assign o_ge_ov      = i_cell_lvl == 2'h3;
   assign o_lt_ov_rel  = i_cell_lvl != 2'h3;
   assign o_lt_uv      = i_cell_lvl == 2'h0;
   assign o_gt_uv_rel  = i_cell_lvl != 2'h0;
   assign o_gt_wake    = i_cell_lvl >= 2'h2;
   assign o_ge_oc      = sense == 3'h1 || sense == 3'h2;
   assign o_ge_sc      = sense == 3'h2;
   assign o_le_oc_rel  = sense == 3'h0 || sense >= 3'h3;
   assign o_le_och     = sense == 3'h3;
   assign o_ge_och_rel = sense != 3'h3;
   assign o_lt_chg_det = sense == 3'h4 && i_charger;
endmodule // pack_model

// file: test/tb_cell_protection_mode_fsm.sv
`timescale 1ns/1ps
module tb_cell_protection_mode_fsm;
   import cell_prot_pkg::*;
   localparam int P   = 20;
   localparam int OCD = 16200;
   logic       i_clock = 1'b0;
   logic       i_sys_rst = 1'b1;
   logic [1:0] cell_lvl = 2'h2;
   logic [2:0] sense_lvl = 3'h0;
   logic       i_charger_present = 1'b0;
   logic       i_load_removed = 1'b0;
   logic       i_cell_ge_ov, i_cell_lt_ov_rel, i_cell_lt_uv, i_cell_gt_uv_rel, i_cell_gt_auto_wake_release_level;
   logic       i_sense_ge_oc, i_sense_ge_short_circuit_level, i_sense_le_oc_rel, i_sense_le_och;
   logic       i_sense_ge_och_rel, i_sense_lt_chg_detect;
   logic       o_charge_path_switch, o_discharge_path_switch, o_sense_pull_up, o_sense_pull_down, o_bias_off;
   mode_t      o_mode;
   logic [4:0] outs;
   int         err_count = 0;
   int         samples_checked = 0;
   assign outs = {o_charge_path_switch, o_discharge_path_switch, o_sense_pull_up, o_sense_pull_down, o_bias_off};
   always #12.5 i_clock = ~i_clock;

   pack_model pack_model_inst (.i_cell_lvl(cell_lvl), .i_sense_lvl(sense_lvl), .i_charger(i_charger_present),
      .i_load_removed(i_load_removed), .i_pull_down(o_sense_pull_down), .o_ge_ov(i_cell_ge_ov),
      .o_lt_ov_rel(i_cell_lt_ov_rel), .o_lt_uv(i_cell_lt_uv), .o_gt_uv_rel(i_cell_gt_uv_rel),
      .o_gt_wake(i_cell_gt_auto_wake_release_level), .o_ge_oc(i_sense_ge_oc),
      .o_ge_sc(i_sense_ge_short_circuit_level), .o_le_oc_rel(i_sense_le_oc_rel), .o_le_och(i_sense_le_och),
      .o_ge_och_rel(i_sense_ge_och_rel), .o_lt_chg_det(i_sense_lt_chg_detect));
   cell_protection_mode_fsm #(.OV_DET_CYCLES(P), .OV_REL_CYCLES(P), .UV_DET_CYCLES(P), .OC_DET_CYCLES(OCD),
      .OC_REL_CYCLES(P), .OCH_DET_CYCLES(P), .OCH_REL_CYCLES(P)) cell_protection_mode_fsm_inst (.i_clock,
      .i_sys_rst, .i_cell_ge_ov, .i_cell_lt_ov_rel, .i_cell_lt_uv, .i_cell_gt_uv_rel,
      .i_cell_gt_auto_wake_release_level, .i_sense_ge_oc, .i_sense_ge_short_circuit_level, .i_sense_le_oc_rel,
      .i_sense_le_och, .i_sense_ge_och_rel, .i_sense_lt_chg_detect, .i_charger_present, .i_load_removed,
      .o_charge_path_switch, .o_discharge_path_switch, .o_sense_pull_up, .o_sense_pull_down, .o_bias_off,
      .o_mode);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge i_clock);
      #2;
   endtask
   task automatic check_mode(input mode_t exp);
      samples_checked++;
      if (o_mode !== exp) begin
         err_count++;
         $display("unexpected mode at %0t: got %s want %s", $time, o_mode.name(), exp.name());
      end
   endtask
   task automatic check_outs(input logic [4:0] exp, input logic [4:0] mask);
      samples_checked++;
      if (((outs ^ exp) & mask) !== 5'h00) begin
         err_count++;
         $display("unexpected outputs at %0t: got %b want %b", $time, outs, exp);
      end
   endtask
   task automatic wait_mode(input mode_t exp, input int limit);
      int n;
      n = 0;
      while (o_mode !== exp && n < limit) begin
         step(1);
         n++;
      end
      check_mode(exp);
   endtask
   task automatic back_normal(input int limit);
      wait_mode(MODE_NORMAL, limit);
      step(2);
      check_outs(5'h18, 5'h1f);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_over_charge();
      check_outs(5'h18, 5'h1f);
      repeat (3) begin
         cell_lvl = 2'h3;
         step(P - 4);
         cell_lvl = 2'h2;
         step(3);
      end
      check_mode(MODE_NORMAL);
      cell_lvl = 2'h3;
      step(P - 1);
      check_mode(MODE_NORMAL);
      wait_mode(MODE_OVERCHARGE, 10);
      check_outs(5'h08, 5'h1f);
      sense_lvl = 3'h1;
      step(3 * P);
      check_mode(MODE_OVERCHARGE);
      sense_lvl = 3'h2;
      step(SC_DET_CYC - 10);
      check_mode(MODE_OVERCHARGE);
      wait_mode(MODE_OV_SHORT, 20);
      check_outs(5'h00, 5'h08);
      step(1);
      check_outs(5'h02, 5'h0a);
      sense_lvl = 3'h0;
      i_load_removed = 1'b1;
      wait_mode(MODE_OVERCHARGE, 10);
      step(2);
      check_outs(5'h08, 5'h1f);
      i_load_removed = 1'b0;
      i_charger_present = 1'b1;
      cell_lvl = 2'h2;
      step(3 * P);
      check_mode(MODE_OVERCHARGE);
      i_charger_present = 1'b0;
      back_normal(P + 10);
      $display("over-charge test done");
   endtask
   task automatic t_discharge();
      sense_lvl = 3'h1;
      step(OCD - 1);
      check_mode(MODE_NORMAL);
      wait_mode(MODE_DISCH_OC, 10);
      step(1);
      check_outs(5'h02, 5'h0a);
      sense_lvl = 3'h0;
      step(3 * P);
      check_mode(MODE_DISCH_OC);
      i_load_removed = 1'b1;
      back_normal(P + 10);
      i_load_removed = 1'b0;
      sense_lvl = 3'h2;
      step(SC_DET_CYC - 10);
      check_mode(MODE_NORMAL);
      wait_mode(MODE_SHORT, 20);
      step(1);
      check_outs(5'h02, 5'h0a);
      sense_lvl = 3'h0;
      i_load_removed = 1'b1;
      step(P - 1);
      check_mode(MODE_SHORT);
      back_normal(10);
      i_load_removed = 1'b0;
      $display("discharge test done");
   endtask
   task automatic t_charge_oc();
      i_charger_present = 1'b1;
      sense_lvl = 3'h3;
      step(P - 1);
      check_mode(MODE_NORMAL);
      wait_mode(MODE_CHARGE_OC, 10);
      check_outs(5'h08, 5'h18);
      sense_lvl = 3'h0;
      step(3 * P);
      check_mode(MODE_CHARGE_OC);
      i_charger_present = 1'b0;
      back_normal(P + 10);
      $display("charge over-current test done");
   endtask
   task automatic t_under_voltage();
      cell_lvl = 2'h0;
      step(P - 1);
      check_mode(MODE_NORMAL);
      wait_mode(MODE_OVERDISCHARGE, 10);
      check_outs(5'h00, 5'h08);
      wait_mode(MODE_STANDBY, 5);
      step(1);
      check_outs(5'h05, 5'h0d);
      i_charger_present = 1'b1;
      wait_mode(MODE_OVERDISCHARGE, 10);
      step(2);
      check_outs(5'h10, 5'h19);
      sense_lvl = 3'h4;
      step(5);
      check_outs(5'h18, 5'h18);
      sense_lvl = 3'h3;
      step(3 * P);
      check_mode(MODE_OVERDISCHARGE);
      sense_lvl = 3'h4;
      cell_lvl = 2'h1;
      step(UV_REL_CYC - 10);
      check_mode(MODE_OVERDISCHARGE);
      back_normal(20);
      i_charger_present = 1'b0;
      sense_lvl = 3'h0;
      cell_lvl = 2'h0;
      wait_mode(MODE_STANDBY, P + 20);
      i_sys_rst = 1'b1;
      step(3);
      check_mode(MODE_NORMAL);
      check_outs(5'h00, 5'h1f);
      i_sys_rst = 1'b0;
      wait_mode(MODE_STANDBY, P + 20);
      cell_lvl = 2'h2;
      back_normal(10);
      $display("under-voltage test done");
   endtask

   initial begin
      repeat (100000) @(posedge i_clock);
      err_count++;
      $display("unexpected timeout at %0t", $time);
      end_of_test();
   end
   initial begin
      step(3);
      i_sys_rst = 1'b0;
      step(4);
      t_over_charge();
      t_discharge();
      t_charge_oc();
      t_under_voltage();
      end_of_test();
   end
endmodule // tb_cell_protection_mode_fsm
